/* hdl/fcdr_top.sv */
// module: fsk edge pulse stage, digital phase loop, window decoder and output buffer
`timescale 1ns/1ps
module fcdr_top (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic limited_rx_signal_i,
  input wire logic carrier_detect_i,
  input wire logic sym_ready_i,
  output logic pulse_width_monitor_o,
  output logic pump_up_n_o,
  output logic pump_down_n_o,
  output logic recovered_bit_clock_o,
  output logic sym_valid_o,
  output logic [2:0] sym_o,
  output logic overflow_o
);
  // ==========================================================
  // edge pulse stage and reference selection
  logic rx_prev, next_rx_prev;
  logic [3:0] os_cnt, next_os_cnt;
  logic ref_div2, next_ref_div2;
  logic [4:0] loc_cnt, next_loc_cnt;
  logic ref_prev, next_ref_prev;
  logic rx_edge, ref_clk, ref_rise;

  assign rx_edge = limited_rx_signal_i ^ rx_prev;

  // a busy one-shot ignores edges so the higher tone is masked
  always_comb begin
    next_rx_prev = limited_rx_signal_i;
    next_os_cnt = os_cnt;
    next_ref_div2 = ref_div2;
    if (os_cnt != 4'h0) begin
      next_os_cnt = os_cnt - 4'h1;
    end else if (rx_edge) begin
      next_os_cnt = 4'(fcdr_pkg::ONESHOT_CYC);
      next_ref_div2 = ~ref_div2;
    end
    // local oscillator divided down to the bit rate
    next_loc_cnt = (loc_cnt == 5'(fcdr_pkg::BIT_CYC - 1)) ? 5'h00 : loc_cnt + 5'h01;
    next_ref_prev = ref_clk;
  end

  assign ref_clk = carrier_detect_i ? ref_div2 : (loc_cnt < 5'(fcdr_pkg::BIT_CYC / 2));
  assign ref_rise = ref_clk & ~ref_prev;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rx_prev <= limited_rx_signal_i; // no false edge on release
      os_cnt <= 4'h0;
      ref_div2 <= 1'b0;
      loc_cnt <= 5'h00;
      ref_prev <= 1'b0;
    end else begin
      rx_prev <= next_rx_prev;
      os_cnt <= next_os_cnt;
      ref_div2 <= next_ref_div2;
      loc_cnt <= next_loc_cnt;
      ref_prev <= next_ref_prev;
    end
  end

  // ==========================================================
  // multivibrator, divide-by-4 feedback and phase detector
  logic [2:0] nco_cnt, next_nco_cnt;
  logic [1:0] fb_q, next_fb_q;
  logic up, next_up;
  logic dn, next_dn;
  logic tick, fb_rise;
  logic [2:0] nco_period;

  // up shortens a quarter; down holds the count, so a feedback lead has no dead zone
  always_comb begin
    nco_period = 3'(fcdr_pkg::QUARTER_CYC);
    if (up) begin
      nco_period = 3'(fcdr_pkg::QUARTER_CYC - 1);
    end
  end

  assign tick = ~dn & (nco_cnt >= nco_period - 3'h1);
  assign fb_rise = tick & (fb_q == 2'h1);

  always_comb begin
    next_nco_cnt = dn ? nco_cnt : (tick ? 3'h0 : nco_cnt + 3'h1);
    next_fb_q = tick ? fb_q + 2'h1 : fb_q;
    next_up = up;
    next_dn = dn;
    // edges together mean zero phase error: neither pump fires
    if (ref_rise && fb_rise) begin
      next_up = 1'b0;
      next_dn = 1'b0;
    end else if (ref_rise) begin
      next_up = ~dn;
      next_dn = 1'b0;
    end else if (fb_rise) begin
      next_dn = ~up;
      next_up = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      nco_cnt <= 3'h0;
      fb_q <= 2'h0;
      up <= 1'b0;
      dn <= 1'b0;
    end else begin
      nco_cnt <= next_nco_cnt;
      fb_q <= next_fb_q;
      up <= next_up;
      dn <= next_dn;
    end
  end

  // ==========================================================
  // window decoder, blanking, pairing and slip
  logic [1:0] slip_ofs, next_slip_ofs;
  logic win1, next_win1;
  logic win3, next_win3;
  logic nd_pend, next_nd_pend;
  logic [1:0] nd_run, next_nd_run;
  logic [4:0] blank_cnt, next_blank_cnt;
  logic cd_prev, next_cd_prev;
  logic [1:0] bitq;
  logic [4:0] bit_pos;
  logic bit_end, push;
  fcdr_pkg::fcdr_sym_t sym_new;
  fcdr_pkg::fcdr_sym_t raw;

  assign bitq = fb_q + slip_ofs;
  assign bit_pos = 5'(bitq) * 5'(fcdr_pkg::QUARTER_CYC) + 5'(nco_cnt);
  assign bit_end = tick & (bitq == 2'h3);

  always_comb begin
    next_win1 = win1;
    next_win3 = win3;
    next_slip_ofs = slip_ofs;
    next_nd_pend = nd_pend;
    next_nd_run = nd_run;
    next_blank_cnt = blank_cnt;
    next_cd_prev = carrier_detect_i;
    sym_new = fcdr_pkg::FCDR_SILENCE;
    push = 1'b0;
    // edges seen inside each window mark the bit
    if (rx_edge && bit_pos >= 5'(fcdr_pkg::WIN1_LO) && bit_pos < 5'(fcdr_pkg::WIN1_HI)) begin
      next_win1 = 1'b1;
    end
    if (rx_edge && bit_pos >= 5'(fcdr_pkg::WIN3_LO) && bit_pos < 5'(fcdr_pkg::WIN3_HI)) begin
      next_win3 = 1'b1;
    end
    case ({win1, win3})
      2'b00: raw = fcdr_pkg::FCDR_ONE;
      2'b11: raw = fcdr_pkg::FCDR_ZERO;
      2'b10: raw = fcdr_pkg::FCDR_ND_FIRST;
      2'b01: raw = fcdr_pkg::FCDR_ND_SECOND;
      default: raw = fcdr_pkg::FCDR_BAD_SIGNAL;
    endcase
    if (carrier_detect_i && !cd_prev) begin
      next_blank_cnt = 5'(fcdr_pkg::BLANK_BITS);
    end
    if (bit_end) begin
      push = 1'b1;
      next_win1 = 1'b0;
      next_win3 = 1'b0;
      if (blank_cnt != 5'h00 && !(carrier_detect_i && !cd_prev)) begin
        next_blank_cnt = blank_cnt - 5'h01;
      end
      if (!carrier_detect_i || blank_cnt != 5'h00 || !cd_prev) begin
        sym_new = fcdr_pkg::FCDR_SILENCE;
        next_nd_pend = 1'b0;
        next_nd_run = 2'h0;
      end else if ((raw == fcdr_pkg::FCDR_ND_FIRST || raw == fcdr_pkg::FCDR_ND_SECOND)
                   && nd_run == 2'(fcdr_pkg::ND_SLIP_RUN - 1)) begin
        // bit clock is half a bit off: slip and resync the pairing
        next_slip_ofs = slip_ofs + 2'h2;
        next_nd_run = 2'h0;
        next_nd_pend = 1'b0;
        sym_new = fcdr_pkg::FCDR_SILENCE;
      end else begin
        next_nd_run = (raw == fcdr_pkg::FCDR_ND_FIRST || raw == fcdr_pkg::FCDR_ND_SECOND) ? nd_run + 2'h1 : 2'h0;
        sym_new = raw;
        next_nd_pend = (raw == fcdr_pkg::FCDR_ND_FIRST);
        // pairing relies on the sender keeping halves in order
        if (nd_pend && raw != fcdr_pkg::FCDR_ND_SECOND) begin
          sym_new = fcdr_pkg::FCDR_BAD_SIGNAL;
        end else if (!nd_pend && raw == fcdr_pkg::FCDR_ND_SECOND) begin
          sym_new = fcdr_pkg::FCDR_BAD_SIGNAL;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      slip_ofs <= 2'h0;
      win1 <= 1'b0;
      win3 <= 1'b0;
      nd_pend <= 1'b0;
      nd_run <= 2'h0;
      blank_cnt <= 5'h00;
      cd_prev <= 1'b0;
    end else begin
      slip_ofs <= next_slip_ofs;
      win1 <= next_win1;
      win3 <= next_win3;
      nd_pend <= next_nd_pend;
      nd_run <= next_nd_run;
      blank_cnt <= next_blank_cnt;
      cd_prev <= next_cd_prev;
    end
  end

  // ==========================================================
  // two-entry symbol buffer
  logic [2:0] buf_mem [fcdr_pkg::BUF_DEPTH];
  logic [2:0] next_buf_mem [fcdr_pkg::BUF_DEPTH];
  logic wr_idx, next_wr_idx;
  logic rd_idx, next_rd_idx;
  logic [1:0] count, next_count;
  logic ovf, next_ovf;
  logic in_ready, do_wr, do_rd;

  // a stream cannot stall, so a word refused when full is flagged
  assign in_ready = (count != 2'(fcdr_pkg::BUF_DEPTH));
  assign do_wr = push & in_ready;
  assign do_rd = sym_valid_o & sym_ready_i;

  always_comb begin
    next_buf_mem = buf_mem;
    next_wr_idx = wr_idx;
    next_rd_idx = rd_idx;
    next_count = count;
    next_ovf = ovf | (push & ~in_ready); // sticky until reset
    if (do_wr) begin
      next_buf_mem[wr_idx] = sym_new;
      next_wr_idx = ~wr_idx;
    end
    if (do_rd) begin
      next_rd_idx = ~rd_idx;
    end
    if (do_wr && !do_rd) begin
      next_count = count + 2'h1;
    end else if (do_rd && !do_wr) begin
      next_count = count - 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      buf_mem[0] <= 3'h0;
      buf_mem[1] <= 3'h0;
      wr_idx <= 1'b0;
      rd_idx <= 1'b0;
      count <= 2'h0;
      ovf <= 1'b0;
    end else begin
      buf_mem <= next_buf_mem;
      wr_idx <= next_wr_idx;
      rd_idx <= next_rd_idx;
      count <= next_count;
      ovf <= next_ovf;
    end
  end

  // ==========================================================
  // outputs
  assign sym_valid_o = (count != 2'h0);
  assign sym_o = buf_mem[rd_idx];
  assign overflow_o = ovf;
  assign pulse_width_monitor_o = (os_cnt != 4'h0);
  assign pump_up_n_o = ~up;
  assign pump_down_n_o = ~dn;
  assign recovered_bit_clock_o = ~bitq[1];
endmodule // fcdr_top

/* hdl/fcdr_pkg.sv */
// package: constants and types for the fsk clock and data recovery block
package fcdr_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int BIT_TIME_NS = 200;
  localparam int ONESHOT_NS = 75; // 75% of a half bit
  localparam int BIT_CYC = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int ONESHOT_CYC = (ONESHOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUARTER_CYC = BIT_CYC / 4;
  localparam int WIN_MARGIN = QUARTER_CYC / 2;
  // loop aligns on the reference rise, two cycles after the line edge that made it
  localparam int EDGE_LAT = 2;
  localparam int WIN1_LO = QUARTER_CYC - WIN_MARGIN - EDGE_LAT;
  localparam int WIN1_HI = QUARTER_CYC + WIN_MARGIN - EDGE_LAT;
  localparam int WIN3_LO = 3 * QUARTER_CYC - WIN_MARGIN - EDGE_LAT;
  localparam int WIN3_HI = 3 * QUARTER_CYC + WIN_MARGIN - EDGE_LAT;
  localparam int BLANK_BITS = 17;
  localparam int ND_SLIP_RUN = 3;
  localparam int BUF_DEPTH = 2;
  // ==========================================================
  // symbols
  typedef enum logic [2:0] {
    FCDR_SILENCE,
    FCDR_ONE,
    FCDR_ZERO,
    FCDR_ND_FIRST,
    FCDR_ND_SECOND,
    FCDR_BAD_SIGNAL
  } fcdr_sym_t;
endpackage

/* verif/fcdr_top_sva.sv */
// checker: port-level properties of the clock and data recovery block
`timescale 1ns/1ps
module fcdr_top_sva (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic limited_rx_signal_i,
  input wire logic carrier_detect_i,
  input wire logic sym_ready_i,
  input wire logic pulse_width_monitor_o,
  input wire logic pump_up_n_o,
  input wire logic pump_down_n_o,
  input wire logic recovered_bit_clock_o,
  input wire logic sym_valid_o,
  input wire logic [2:0] sym_o,
  input wire logic overflow_o
);
  // =====
  // one-shot and phase detector
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // full width, then idle again: a retrigger would stretch it
  sequence s_pulse;
    pulse_width_monitor_o [*8] ##1 !pulse_width_monitor_o;
  endsequence
  property p_pulse_len; $rose(pulse_width_monitor_o) |-> s_pulse; endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("one-shot width wrong");
  property p_pulse_trig; (!pulse_width_monitor_o && $changed(limited_rx_signal_i)) |-> ##[1:3] pulse_width_monitor_o; endproperty
  a_pulse_trig: assert property (p_pulse_trig) else $error("one-shot missed an edge");
  property p_pump_excl; !(!pump_up_n_o && !pump_down_n_o); endproperty
  a_pump_excl: assert property (p_pump_excl) else $error("both pumps active");
  // feedback period is 20 cycles unpumped, 16 under pump-up, so a pump pulse must end by then
  property p_up_bound; $fell(pump_up_n_o) |-> ##[1:30] pump_up_n_o; endproperty
  a_up_bound: assert property (p_up_bound) else $error("pump-up stuck");
  property p_dn_bound; $fell(pump_down_n_o) |-> ##[1:30] pump_down_n_o; endproperty
  a_dn_bound: assert property (p_dn_bound) else $error("pump-down stuck");
  // =====
  // symbol buffer
  property p_sym_hold; (sym_valid_o && !sym_ready_i) |=> sym_valid_o && $stable(sym_o); endproperty
  a_sym_hold: assert property (p_sym_hold) else $error("symbol dropped while stalled");
  property p_ovf_sticky; overflow_o |=> overflow_o; endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow cleared");
  property p_ovf_cause; $rose(overflow_o) |-> $past(sym_valid_o) && !$past(sym_ready_i); endproperty
  a_ovf_cause: assert property (p_ovf_cause) else $error("overflow without full buffer");
  property p_sym_legal; sym_valid_o |-> sym_o <= 3'h5; endproperty
  a_sym_legal: assert property (p_sym_legal) else $error("illegal symbol code");
endmodule // fcdr_top_sva

/* verif/fcdr_rx_source.sv */
// partner: limiter output carrying the two-tone symbol stream
`timescale 1ns/1ps
module fcdr_rx_source (
  input wire logic clk_i,
  input wire logic [2:0] sym_i,
  output logic line_o,
  output logic bit_start_o
);
  logic [4:0] pos;
  logic [2:0] cur;
  initial begin
    pos = 5'h00;
    cur = 3'h1;
    line_o = 1'b0;
  end
  // =====
  // 20-cycle bit; start and mid edges always, quarter marks per symbol
  always @(posedge clk_i) begin
    pos <= (pos == 5'h13) ? 5'h00 : pos + 5'h01;
    if (pos == 5'h00) cur <= sym_i;
    if (pos == 5'h00 || pos == 5'h0A) line_o <= ~line_o;
    if (pos == 5'h05 && (cur == fcdr_pkg::FCDR_ZERO || cur == fcdr_pkg::FCDR_ND_FIRST)) line_o <= ~line_o;
    if (pos == 5'h0F && (cur == fcdr_pkg::FCDR_ZERO || cur == fcdr_pkg::FCDR_ND_SECOND)) line_o <= ~line_o;
  end
  assign bit_start_o = (pos == 5'h00);
endmodule // fcdr_rx_source

/* verif/tb_fsk_clock_data_recovery.sv */
// testbench: self-checking run of the clock and data recovery block
`timescale 1ns/1ps
module tb_fsk_clock_data_recovery;
  // =====
  // harness
  logic clk_i, reset_i, line, carrier, ready, pwm, up_n, dn_n, rbc, valid, ovf, bit_start;
  logic [2:0] sym;
  logic [2:0] src_sym;
  logic [2:0] got[$];
  int n_errors = 0;
  int samples_checked = 0;
  fcdr_rx_source u_src (.clk_i(clk_i), .sym_i(src_sym), .line_o(line), .bit_start_o(bit_start));
  fcdr_top u_dut (.clk_i(clk_i), .reset_i(reset_i), .limited_rx_signal_i(line), .carrier_detect_i(carrier),
    .sym_ready_i(ready), .pulse_width_monitor_o(pwm), .pump_up_n_o(up_n), .pump_down_n_o(dn_n),
    .recovered_bit_clock_o(rbc), .sym_valid_o(valid), .sym_o(sym), .overflow_o(ovf));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // log every accepted symbol in order
  always @(posedge clk_i) begin
    if (!reset_i && valid === 1'b1 && ready === 1'b1) got.push_back(sym);
  end
  // =====
  // shared tasks
  task automatic complete_run();
    if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [2:0] seen, input logic [2:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one symbol per sender bit; waits for the sender's bit start
  task automatic send(input logic [2:0] s);
    int k;
    k = 0;
    while (bit_start !== 1'b1 && k < 30) begin
      @(negedge clk_i);
      k++;
    end
    if (k == 30) begin
      n_errors++;
      complete_run();
    end
    src_sym = s;
    @(negedge clk_i);
  endtask
  function automatic logic has_seq(input logic [2:0] p[]);
    for (int i = 0; i + p.size() <= got.size(); i++) begin
      for (int j = 0; j < p.size() && got[i + j] === p[j]; j++) begin
        if (j == p.size() - 1) return 1'b1;
      end
    end
    return 1'b0;
  endfunction
  // =====
  // scenarios
  task automatic sc_quiet();
    carrier = 1'b0;
    repeat (6) send(fcdr_pkg::FCDR_ONE);
    check("quiet_count", {2'h0, got.size() >= 4 && got.size() <= 7}, 3'h1);
    foreach (got[i]) check("quiet_sym", got[i], fcdr_pkg::FCDR_SILENCE);
  endtask
  task automatic sc_lock();
    int n_low;
    int n_rise;
    logic rbc_q;
    got.delete();
    carrier = 1'b1;
    repeat (16) begin
      send(fcdr_pkg::FCDR_ONE);
      send(fcdr_pkg::FCDR_ZERO);
    end
    for (int i = 0; i < 17; i++) check("blank_sym", got[i], fcdr_pkg::FCDR_SILENCE);
    // non-data only as first-second pairs
    send(fcdr_pkg::FCDR_ZERO);
    send(fcdr_pkg::FCDR_ND_FIRST);
    send(fcdr_pkg::FCDR_ND_SECOND);
    repeat (4) send(fcdr_pkg::FCDR_ONE);
    check("data_seq", {2'h0, has_seq('{3'h2, 3'h3, 3'h4, 3'h1, 3'h1})}, 3'h1);
    // locked: pumps only spike and the bit clock runs at the bit rate
    n_low = 0;
    n_rise = 0;
    rbc_q = rbc;
    repeat (40) begin
      @(negedge clk_i);
      if (up_n !== 1'b1 || dn_n !== 1'b1) n_low++;
      if (rbc === 1'b1 && rbc_q === 1'b0) n_rise++;
      rbc_q = rbc;
    end
    check("lock_pumps", {2'h0, n_low <= 4}, 3'h1);
    check("lock_bit_clock", 3'(n_rise), 3'h2);
  endtask
  task automatic sc_bad();
    got.delete();
    send(fcdr_pkg::FCDR_ND_FIRST);
    send(fcdr_pkg::FCDR_ONE);
    send(fcdr_pkg::FCDR_ND_SECOND);
    repeat (4) send(fcdr_pkg::FCDR_ONE);
    check("bad_seq", {2'h0, has_seq('{3'h3, 3'h5, 3'h5, 3'h1})}, 3'h1);
  endtask
  // stall the receiver until a word is lost, then drain
  task automatic sc_ovf();
    ready = 1'b0;
    repeat (5) send(fcdr_pkg::FCDR_ONE);
    check("full_flags", {valid, ovf, 1'b0}, 3'h6);
    // release mid-bit so no new symbol lands while draining
    repeat (8) @(negedge clk_i);
    ready = 1'b1;
    repeat (3) @(negedge clk_i);
    check("drain_flags", {valid, ovf, 1'b0}, 3'h2);
  endtask
  // =====
  // main sequence
  initial begin
    reset_i = 1'b1;
    carrier = 1'b0;
    ready = 1'b1;
    src_sym = fcdr_pkg::FCDR_ONE;
    repeat (5) @(negedge clk_i);
    reset_i = 1'b0;
    check("rst_pump_clk", {up_n, dn_n, rbc}, 3'h7);
    check("rst_flags", {valid, ovf, pwm}, 3'h0);
    sc_quiet();
    sc_lock();
    sc_bad();
    sc_ovf();
    complete_run();
  end
endmodule // tb_fsk_clock_data_recovery
bind fcdr_top fcdr_top_sva u_sva (.clk_i(clk_i), .reset_i(reset_i), .limited_rx_signal_i(limited_rx_signal_i),
  .carrier_detect_i(carrier_detect_i), .sym_ready_i(sym_ready_i), .pulse_width_monitor_o(pulse_width_monitor_o),
  .pump_up_n_o(pump_up_n_o), .pump_down_n_o(pump_down_n_o), .recovered_bit_clock_o(recovered_bit_clock_o),
  .sym_valid_o(sym_valid_o), .sym_o(sym_o), .overflow_o(overflow_o));
